// ===== logic/ipa_interrupt_priority_arbiter.sv
// Interrupt priority and vectoring arbiter with its AHB-Lite register slave.
//
// Operation
// - separate core and peripheral priority registers
// - two-bit level field, 00 off, else 0..2
// - fixed order among the six level-3 sources
// - external lines A..D lead each of levels 0..2
// - DMA channels 0..5 follow external lines
// - first audio port, then serial host order
// - host port, transmitter, then timers follow
// - second audio port ranks lowest of all
// - level-3 vector is base plus fixed offset
// - reserved level-3 slots never raise anything
// - external and DMA vectors at fixed offsets
//
// Implementation choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module ipa_interrupt_priority_arbiter
    import ipa_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Level-3 request lines from the core's exception logic.
    input wire logic hwResetReq,
    input wire logic stackErrReq,
    input wire logic illegalInstrReq,
    input wire logic debugReq,
    input wire logic trapReq,
    input wire logic nmiReq,
    // Maskable request lines, each group in its own fixed order.
    input wire logic extInterruptLineA,
    input wire logic extInterruptLineB,
    input wire logic extInterruptLineC,
    input wire logic extInterruptLineD,
    input wire logic [5:0] dmaChanReq,
    input wire logic [7:0] audioSerialPortFirstReq,
    input wire logic [5:0] serialHostPortReq,
    input wire logic [2:0] hostPortReq,
    input wire logic [2:0] digitalAudioTransmitterReq,
    input wire logic [5:0] timerReq,
    input wire logic [7:0] audioSerialPortSecondReq,
    // Towards the program sequencer.
    output logic irqPending,
    output logic [1:0] irqLevel,
    output logic [23:0] irqVector,
    output logic [5:0] irqSourceIdx,
    // Summary interrupt from the sticky status register.
    output logic irqOut
);

    // ========================================================================
    // Registers
    // ========================================================================
    logic [IPA_CORE_PRIO_W-1:0] corePriorityReg;
    logic [IPA_PERIPH_PRIO_W-1:0] periphPriorityReg;
    logic [IPA_VEC_W-1:0] vectorBase;
    logic [IPA_STAT_W-1:0] status;
    logic [IPA_STAT_W-1:0] mask;
    logic wrPending;
    logic [IPA_ADDR_DEC_W-1:0] wrAddr;

    // ========================================================================
    // Bus decode
    // ========================================================================
    wire logic accept = hsel && htrans[1] && hready;
    wire logic rdAccept = accept && !hwrite;
    wire logic wrAccept = accept && hwrite;
    wire logic [IPA_ADDR_DEC_W-1:0] rdAddr = haddr[IPA_ADDR_DEC_W-1:0];
    wire logic wrCore = wrPending && (wrAddr == IPA_OFS_CORE_PRIO);
    wire logic wrPeriph = wrPending && (wrAddr == IPA_OFS_PERIPH_PRIO);
    wire logic wrBase = wrPending && (wrAddr == IPA_OFS_VECTOR_BASE);
    wire logic wrMask = wrPending && (wrAddr == IPA_OFS_MASK);
    wire logic rdStatus = rdAccept && (rdAddr == IPA_OFS_STATUS);

    // ========================================================================
    // Source gathering
    // ========================================================================
    // external lines first
    wire logic [IPA_NUM_MASKABLE-1:0] maskReq = {
        audioSerialPortSecondReq[7:0],
        timerReq[5:0],
        digitalAudioTransmitterReq[2:0],
        hostPortReq[2:0],
        serialHostPortReq[5:0],
        audioSerialPortFirstReq[7:0],
        dmaChanReq[5:0],
        extInterruptLineD,
        extInterruptLineC,
        extInterruptLineB,
        extInterruptLineA
    };

    wire logic [IPA_NUM_NMI-1:0] nmiReqs = {
        nmiReq, trapReq, debugReq, illegalInstrReq, stackErrReq, hwResetReq
    };

    wire logic [2*IPA_NUM_FIELDS-1:0] allFields = {
        periphPriorityReg, corePriorityReg
    };

    // ========================================================================
    // Level sorting
    // ========================================================================
    logic [IPA_NUM_MASKABLE-1:0] lvlReq0;
    logic [IPA_NUM_MASKABLE-1:0] lvlReq1;
    logic [IPA_NUM_MASKABLE-1:0] lvlReq2;
    logic [IPA_NUM_MASKABLE-1:0] droppedVec;

    for (genvar s = 0; s < IPA_NUM_MASKABLE; s++) begin : g_gate
        localparam int F = int'(IPA_SRC_FIELD[s]);
        logic [2:0] lvl;
        ipa_level_gate #(
            .FIELD_W(2)
        ) u_gate (
            .req(maskReq[s]),
            .levelField(allFields[2*F+1:2*F]),
            .levelReq(lvl),
            .dropped(droppedVec[s])
        );
        assign lvlReq0[s] = lvl[0];
        assign lvlReq1[s] = lvl[1];
        assign lvlReq2[s] = lvl[2];
    end

    // ========================================================================
    // Fixed-order encoders per level
    // ========================================================================
    logic found0;
    logic found1;
    logic found2;
    logic found3;
    logic [5:0] idx0;
    logic [5:0] idx1;
    logic [5:0] idx2;
    logic [5:0] idx3;

    ipa_prio_enc #(
        .N(IPA_NUM_MASKABLE)
    ) u_enc0 (
        .req(lvlReq0),
        .found(found0),
        .idx(idx0)
    );

    ipa_prio_enc #(
        .N(IPA_NUM_MASKABLE)
    ) u_enc1 (
        .req(lvlReq1),
        .found(found1),
        .idx(idx1)
    );

    ipa_prio_enc #(
        .N(IPA_NUM_MASKABLE)
    ) u_enc2 (
        .req(lvlReq2),
        .found(found2),
        .idx(idx2)
    );

    ipa_prio_enc #(
        .N(IPA_NUM_NMI)
    ) u_enc3 (
        .req(nmiReqs),
        .found(found3),
        .idx(idx3)
    );

    // ========================================================================
    // Winner selection and vector forming
    // ========================================================================
    // level 3, then 2, 1, 0
    wire logic [5:0] winMaskIdx = found2 ? idx2 : (found1 ? idx1 : idx0);
    wire logic [1:0] winMaskLvl = found2 ? 2'h2 : (found1 ? 2'h1 : 2'h0);
    wire logic anyMaskable = found0 || found1 || found2;
    wire logic next_irqPending = found3 || anyMaskable;
    wire logic [1:0] next_irqLevel = found3 ? IPA_LEVEL_NMI : winMaskLvl;
    wire logic [5:0] next_irqSourceIdx = found3 ? idx3 : winMaskIdx;
    // The vector is formed even when nothing is pending, so it then shows
    // the first maskable slot; the sequencer must qualify it by irqPending.
    // level-3 offsets
    wire logic [7:0] winOffset = found3 ? IPA_NMI_VEC[idx3[2:0]]
                                        : IPA_MASK_VEC[winMaskIdx];
    wire logic [23:0] next_irqVector = vectorBase + {16'h0000, winOffset};

    // ========================================================================
    // Sticky status and summary interrupt
    // ========================================================================
    wire logic [IPA_STAT_W-1:0] statSet = {
        |droppedVec, found3 ? 1'b0 : anyMaskable, nmiReqs
    };
    // A new event in the clearing cycle survives the read.
    wire logic [IPA_STAT_W-1:0] next_status =
        (status & ~(rdStatus ? {IPA_STAT_W{1'b1}} : {IPA_STAT_W{1'b0}}))
        | statSet;
    wire logic next_irqOut = |(next_status & mask);

    // ========================================================================
    // Read data
    // ========================================================================
    wire logic [31:0] curWord = {
        5'h00, irqPending, irqLevel, irqVector
    };
    wire logic [31:0] next_hrdata =
        !rdAccept ? 32'h00000000 :
        (rdAddr == IPA_OFS_CORE_PRIO) ? {12'h000, corePriorityReg} :
        (rdAddr == IPA_OFS_PERIPH_PRIO) ? {20'h00000, periphPriorityReg} :
        (rdAddr == IPA_OFS_VECTOR_BASE) ? {8'h00, vectorBase} :
        (rdAddr == IPA_OFS_STATUS) ? {24'h000000, status} :
        (rdAddr == IPA_OFS_MASK) ? {24'h000000, mask} :
        (rdAddr == IPA_OFS_CURRENT) ? curWord :
        32'h00000000;

    // ========================================================================
    // Bus side flip-flops
    // ========================================================================
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wrPending <= 1'b0;
            wrAddr <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            wrPending <= wrAccept;
            wrAddr <= rdAddr;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            corePriorityReg <= IPA_RST_CORE_PRIO;
            periphPriorityReg <= IPA_RST_PERIPH_PRIO;
            vectorBase <= IPA_RST_VECTOR_BASE;
            mask <= IPA_RST_MASK;
        end else begin
            if (wrCore) begin
                corePriorityReg <= hwdata[IPA_CORE_PRIO_W-1:0];
            end
            if (wrPeriph) begin
                periphPriorityReg <= hwdata[IPA_PERIPH_PRIO_W-1:0];
            end
            if (wrBase) begin
                vectorBase <= hwdata[IPA_VEC_W-1:0];
            end
            if (wrMask) begin
                mask <= hwdata[IPA_STAT_W-1:0];
            end
        end
    end

    // ========================================================================
    // Arbitration result and status flip-flops
    // ========================================================================
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irqPending <= 1'b0;
            irqLevel <= 2'h0;
            irqVector <= 24'h000000;
            irqSourceIdx <= 6'h00;
            status <= IPA_RST_STATUS;
            irqOut <= 1'b0;
        end else begin
            irqPending <= next_irqPending;
            irqLevel <= next_irqLevel;
            irqVector <= next_irqVector;
            irqSourceIdx <= next_irqSourceIdx;
            status <= next_status;
            irqOut <= next_irqOut;
        end
    end

endmodule

`default_nettype wire

// ===== logic/ipa_pkg.sv
// Package with register map, field layout and vector tables of the arbiter.
package ipa_pkg;

    // ========================================================================
    // Register map (byte addresses on the AHB-Lite slave)
    // ========================================================================
    localparam logic [7:0] IPA_OFS_CORE_PRIO = 8'h00;
    localparam logic [7:0] IPA_OFS_PERIPH_PRIO = 8'h04;
    localparam logic [7:0] IPA_OFS_VECTOR_BASE = 8'h08;
    localparam logic [7:0] IPA_OFS_STATUS = 8'h0C;
    localparam logic [7:0] IPA_OFS_MASK = 8'h10;
    localparam logic [7:0] IPA_OFS_CURRENT = 8'h14;
    localparam int IPA_ADDR_DEC_W = 8;

    // ========================================================================
    // Reset values
    // ========================================================================
    localparam logic [19:0] IPA_RST_CORE_PRIO = 20'h00000;
    localparam logic [11:0] IPA_RST_PERIPH_PRIO = 12'h000;
    localparam logic [23:0] IPA_RST_VECTOR_BASE = 24'h000000;
    localparam logic [7:0] IPA_RST_STATUS = 8'h00;
    localparam logic [7:0] IPA_RST_MASK = 8'h00;

    // ========================================================================
    // Field layout
    // ========================================================================
    localparam int IPA_CORE_PRIO_W = 20;
    localparam int IPA_PERIPH_PRIO_W = 12;
    localparam int IPA_VEC_W = 24;
    localparam int IPA_NUM_FIELDS = 16;
    localparam int IPA_NUM_MASKABLE = 44;
    localparam int IPA_NUM_NMI = 6;
    localparam int IPA_STAT_W = 8;
    localparam int IPA_STAT_MASKABLE_BIT = 6;
    localparam int IPA_STAT_DROPPED_BIT = 7;
    localparam int IPA_CUR_LEVEL_LSB = 24;
    localparam int IPA_CUR_PENDING_BIT = 26;
    localparam logic [1:0] IPA_LEVEL_NMI = 2'h3;

    // Level field that each maskable source obeys, in priority order.
    // Fields 0..9 sit in the core register, 10..15 in the peripheral one.
    localparam logic [3:0] IPA_SRC_FIELD [0:IPA_NUM_MASKABLE-1] = '{
        4'h0, 4'h1, 4'h2, 4'h3,
        4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9,
        4'hA, 4'hA, 4'hA, 4'hA, 4'hA, 4'hA, 4'hA, 4'hA,
        4'hB, 4'hB, 4'hB, 4'hB, 4'hB, 4'hB,
        4'hC, 4'hC, 4'hC,
        4'hD, 4'hD, 4'hD,
        4'hE, 4'hE, 4'hE, 4'hE, 4'hE, 4'hE,
        4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF
    };

    // Vector offset of each maskable source, in priority order.
    localparam logic [7:0] IPA_MASK_VEC [0:IPA_NUM_MASKABLE-1] = '{
        8'h10, 8'h12, 8'h14, 8'h16,
        8'h18, 8'h1A, 8'h1C, 8'h1E, 8'h20, 8'h22,
        8'h34, 8'h32, 8'h30, 8'h36, 8'h3C, 8'h3E, 8'h3A, 8'h38,
        8'h4C, 8'h4A, 8'h42, 8'h48, 8'h40, 8'h44,
        8'h64, 8'h60, 8'h62,
        8'h28, 8'h2A, 8'h2E,
        8'h56, 8'h54, 8'h5A, 8'h58, 8'h5E, 8'h5C,
        8'h74, 8'h72, 8'h70, 8'h76, 8'h7C, 8'h7E, 8'h7A, 8'h78
    };

    // Vector offset of each level-3 source, in priority order.
    localparam logic [7:0] IPA_NMI_VEC [0:IPA_NUM_NMI-1] = '{
        8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0A
    };

endpackage

// ===== logic/ipa_level_gate.sv
// Per-source gate that sorts one request into its enabled priority level.
`timescale 1ns/1ps
`default_nettype none

module ipa_level_gate #(
    parameter int FIELD_W = 2
) (
    input wire logic req,
    input wire logic [FIELD_W-1:0] levelField,
    output logic [2:0] levelReq,
    output logic dropped
);

    // Code 0 disables; codes 1..3 map to levels 0..2.
    assign levelReq[0] = req && (levelField == 2'h1);
    assign levelReq[1] = req && (levelField == 2'h2);
    assign levelReq[2] = req && (levelField == 2'h3);
    assign dropped = req && (levelField == 2'h0);

endmodule

`default_nettype wire

// ===== logic/ipa_prio_enc.sv
// Fixed-order priority encoder: the lowest index that requests wins.
`timescale 1ns/1ps
`default_nettype none

module ipa_prio_enc #(
    parameter int N = 44
) (
    input wire logic [N-1:0] req,
    output logic found,
    output logic [5:0] idx
);

    always_comb begin
        idx = 6'h00;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = 6'(i);
            end
        end
    end

    assign found = |req;

endmodule

`default_nettype wire

// ===== testbench/ipa_sva.sv
// Checker of the arbitration outcome at the arbiter's ports.
`timescale 1ns/1ps
`default_nettype none
module ipa_sva (
    input wire logic clk,
    input wire logic nrst,
    input wire logic hwResetReq,
    input wire logic stackErrReq,
    input wire logic illegalInstrReq,
    input wire logic debugReq,
    input wire logic trapReq,
    input wire logic nmiReq,
    input wire logic extInterruptLineA,
    input wire logic extInterruptLineB,
    input wire logic extInterruptLineC,
    input wire logic extInterruptLineD,
    input wire logic [5:0] dmaChanReq,
    input wire logic [7:0] audioSerialPortFirstReq,
    input wire logic [5:0] serialHostPortReq,
    input wire logic [2:0] hostPortReq,
    input wire logic [2:0] digitalAudioTransmitterReq,
    input wire logic [5:0] timerReq,
    input wire logic [7:0] audioSerialPortSecondReq,
    input wire logic irqPending,
    input wire logic [1:0] irqLevel,
    input wire logic [5:0] irqSourceIdx
);
    wire logic [5:0] l3w;
    wire logic [43:0] mw;
    logic [5:0] l3Q;
    logic [43:0] mQ;
    assign l3w = {nmiReq, trapReq, debugReq, illegalInstrReq, stackErrReq,
        hwResetReq};
    assign mw = {audioSerialPortSecondReq, timerReq,
        digitalAudioTransmitterReq, hostPortReq, serialHostPortReq,
        audioSerialPortFirstReq, dmaChanReq, extInterruptLineD,
        extInterruptLineC, extInterruptLineB, extInterruptLineA};
    // Requests as seen by the edge that also updates the outputs.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            l3Q <= 6'h00;
            mQ <= '0;
        end else begin
            l3Q <= l3w;
            mQ <= mw;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // ========================================================================
    // Assertions
    // ========================================================================
    a_reset_first: assert property (
        hwResetReq |=> irqSourceIdx == 6'h00 && irqLevel == 2'h3)
        else $error("reset request did not win");
    a_stack_second: assert property (
        stackErrReq && !hwResetReq |=> irqSourceIdx == 6'h01)
        else $error("stack error did not rank second");
    a_nmi_last: assert property (
        l3w == 6'h20 |=> irqSourceIdx == 6'h05 && irqLevel == 2'h3)
        else $error("lone external level-3 request lost");
    a_level3_wins: assert property (
        |l3w |=> irqPending && irqLevel == 2'h3)
        else $error("level-3 request not served at level 3");
    a_mask_alone: assert property (
        irqPending && irqLevel != 2'h3 |-> l3Q == 6'h00)
        else $error("maskable winner while level-3 pending");
    a_no_reserved: assert property (
        irqPending && irqLevel == 2'h3 |-> irqSourceIdx < 6'h06)
        else $error("reserved level-3 slot raised");
    a_winner_real: assert property (
        irqPending && irqLevel != 2'h3 |-> mQ[irqSourceIdx])
        else $error("winner was not requesting");
    a_idle_quiet: assert property (
        l3w == 6'h00 && mw == '0 |=> !irqPending)
        else $error("pending without any request");
    c_level3: cover property (|l3w ##1 irqLevel == 2'h3);
    c_level0: cover property (irqPending && irqLevel == 2'h0);
    c_lowest: cover property (irqPending && irqSourceIdx == 6'h2B);
endmodule
bind ipa_interrupt_priority_arbiter ipa_sva i_sva (.*);
`default_nettype wire

// ===== testbench/ipa_src_model.sv
// Request sources: core exception logic and peripheral request lines.
`timescale 1ns/1ps
`default_nettype none
module ipa_src_model (
    input wire logic [49:0] reqWord,
    output logic hwRst,
    output logic stkErr,
    output logic illIns,
    output logic dbgReq,
    output logic trpReq,
    output logic nmiReq,
    output logic extA,
    output logic extB,
    output logic extC,
    output logic extD,
    output logic [5:0] dma,
    output logic [7:0] asp1,
    output logic [5:0] shp,
    output logic [2:0] host,
    output logic [2:0] digital_audio_transmitter,
    output logic [5:0] tmr,
    output logic [7:0] asp2
);
    // Bit i of the upper 44 bits is the source ranked i; low six bits are
    // the level-3 lines, so one word states any mix of requests.
    assign {asp2, tmr, digital_audio_transmitter, host, shp, asp1, dma, extD, extC, extB, extA,
        nmiReq, trpReq, dbgReq, illIns, stkErr, hwRst} = reqWord;
endmodule
`default_nettype wire

// ===== testbench/interrupt_priority_arbiter_test.sv
// Self-checking bench of the interrupt priority arbiter.
`timescale 1ns/1ps
`default_nettype none
module interrupt_priority_arbiter_test
    import ipa_pkg::*;
;
    logic clk, nrst, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, irqLevel;
    logic [2:0] hsize;
    logic [49:0] reqWord;
    logic hwRst, stkErr, illIns, dbgReq, trpReq, nmiReq;
    logic extA, extB, extC, extD, irqPending, irqOut;
    logic [5:0] dma, shp, tmr, irqSourceIdx;
    logic [7:0] asp1, asp2;
    logic [2:0] host, digital_audio_transmitter;
    logic [23:0] irqVector;
    int fails, samples_checked, cycles;
    localparam logic [23:0] BASE = 24'h0C3A00;
    ipa_src_model i_src (.reqWord(reqWord), .hwRst(hwRst), .stkErr(stkErr),
        .illIns(illIns), .dbgReq(dbgReq), .trpReq(trpReq), .nmiReq(nmiReq),
        .extA(extA), .extB(extB), .extC(extC), .extD(extD), .dma(dma),
        .asp1(asp1), .shp(shp), .host(host), .digital_audio_transmitter(digital_audio_transmitter), .tmr(tmr),
        .asp2(asp2));
    ipa_interrupt_priority_arbiter i_dut (.clk(clk), .nrst(nrst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .hwResetReq(hwRst), .stackErrReq(stkErr), .illegalInstrReq(illIns),
        .debugReq(dbgReq), .trapReq(trpReq), .nmiReq(nmiReq),
        .extInterruptLineA(extA), .extInterruptLineB(extB),
        .extInterruptLineC(extC), .extInterruptLineD(extD),
        .dmaChanReq(dma), .audioSerialPortFirstReq(asp1),
        .serialHostPortReq(shp), .hostPortReq(host),
        .digitalAudioTransmitterReq(digital_audio_transmitter), .timerReq(tmr),
        .audioSerialPortSecondReq(asp2), .irqPending(irqPending),
        .irqLevel(irqLevel), .irqVector(irqVector),
        .irqSourceIdx(irqSourceIdx), .irqOut(irqOut));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ========================================================================
    // Shared tasks
    // ========================================================================
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h000000, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic go(input logic [49:0] w);
        @(posedge clk);
        reqWord <= w;
        @(posedge clk);
        @(negedge clk);
    endtask
    // Idle outputs are judged on the pending flag and the vector alone.
    task automatic want(input logic [8:0] s, input logic [7:0] ofs);
        chk({31'h0, irqPending}, {31'h0, s[8]});
        chk({8'h00, irqVector}, {8'h00, BASE + {16'h0000, ofs}});
        if (s[8]) begin
            chk({23'h0, irqPending, irqLevel, irqSourceIdx}, {23'h0, s});
        end
    endtask
    // ========================================================================
    // Scenarios
    // ========================================================================
    task automatic t_regs();
        for (int i = 0; i < 7; i++) begin
            bus(1'b0, 8'(4 * i), 32'h0);
            // The idle vector already shows the first maskable slot.
            chk(rd, (8'(4 * i) == IPA_OFS_CURRENT) ?
                {24'h000000, IPA_MASK_VEC[0]} : 32'h0);
        end
        bus(1'b1, IPA_OFS_CORE_PRIO, 32'hFFFFFFFF);
        bus(1'b1, IPA_OFS_PERIPH_PRIO, 32'hFFFFFAAA);
        bus(1'b1, 8'h18, 32'hFFFFFFFF);
        bus(1'b1, IPA_OFS_VECTOR_BASE, {8'h00, BASE});
        bus(1'b0, IPA_OFS_CORE_PRIO, 32'h0);
        chk(rd, 32'h000FFFFF);
        bus(1'b0, IPA_OFS_PERIPH_PRIO, 32'h0);
        chk(rd, 32'h00000AAA);
        bus(1'b0, 8'h18, 32'h0);
        chk(rd, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_order();
        bus(1'b1, IPA_OFS_CORE_PRIO, 32'h00055555);
        bus(1'b1, IPA_OFS_PERIPH_PRIO, 32'h00000555);
        for (int i = 0; i < 44; i++) begin
            go({44'(~44'h0 << i), 6'h00});
            want({3'b100, 6'(i)}, i < 10 ? 8'(16 + 2 * i) : IPA_MASK_VEC[i]);
        end
        $display("test order done");
    endtask
    task automatic t_l3();
        for (int i = 0; i < 8; i++) begin
            go({~44'h0, 6'(6'h3F << i)});
            if (i < 6) want({3'b111, 6'(i)}, 8'(2 * i));
            else want({3'b100, 6'h00}, 8'h10);
        end
        $display("test level3 done");
    endtask
    task automatic t_levels();
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, IPA_OFS_CORE_PRIO, 32'(c));
            go(50'h40);
            want({c != 0, 2'(c - 1), 6'h00}, 8'h10);
        end
        bus(1'b1, IPA_OFS_CORE_PRIO, 32'h1);
        bus(1'b1, IPA_OFS_PERIPH_PRIO, 32'hC00);
        go({1'b1, 42'h0, 7'h40});
        want({3'b110, 6'h2B}, 8'h78);
        $display("test levels done");
    endtask
    task automatic t_irq();
        go(50'h0);
        bus(1'b0, IPA_OFS_STATUS, 32'h0);
        bus(1'b1, IPA_OFS_MASK, 32'h20);
        go(50'h20);
        go(50'h0);
        chk({31'h0, irqOut}, 32'h1);
        bus(1'b1, IPA_OFS_MASK, 32'h0);
        // The output follows a new mask one edge after the mask lands.
        repeat (2) @(negedge clk);
        chk({31'h0, irqOut}, 32'h0);
        bus(1'b1, IPA_OFS_MASK, 32'h20);
        repeat (2) @(negedge clk);
        chk({31'h0, irqOut}, 32'h1);
        bus(1'b0, IPA_OFS_STATUS, 32'h0);
        chk(rd, 32'h20);
        @(negedge clk);
        chk({31'h0, irqOut}, 32'h0);
        // A level-0 winner plus a request on a disabled channel; the second
        // read shows that an event still standing outlives the clear.
        go(50'h440);
        bus(1'b0, IPA_OFS_STATUS, 32'h0);
        chk(rd, 32'hC0);
        bus(1'b0, IPA_OFS_STATUS, 32'h0);
        chk(rd, 32'hC0);
        $display("test irq done");
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            results();
        end
    end
    initial begin
        {nrst, hsel, hwrite, htrans, haddr, hwdata} = '0;
        {reqWord, fails, samples_checked, cycles} = '0;
        hsize = 3'h2;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_order();
        t_l3();
        t_levels();
        t_irq();
        results();
    end
endmodule
`default_nettype wire
